// >>> include/tmr_pkg.sv
// package of constants for the timer compare/interrupt block
// assumes a byte-wide special function register port and one system clock
package tmr_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CNT_LOW   = 8'he2;
  localparam logic [7:0] ADDR_CNT_HIGH  = 8'he3;
  localparam logic [7:0] ADDR_CTL       = 8'he4;
  localparam logic [7:0] ADDR_CCTL0     = 8'he5;
  localparam logic [7:0] ADDR_CCTL1     = 8'he6;
  localparam logic [7:0] ADDR_CCTL2     = 8'he7;
  localparam logic [7:0] ADDR_CC0L      = 8'hda;
  localparam logic [7:0] ADDR_CC0H      = 8'hdb;
  localparam logic [7:0] ADDR_CC1L      = 8'hdc;
  localparam logic [7:0] ADDR_CC1H      = 8'hdd;
  localparam logic [7:0] ADDR_CC2L      = 8'hde;
  localparam logic [7:0] ADDR_CC2H      = 8'hdf;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'hd8;
  // field positions
  localparam int CTL_FLAG_LSB = 4;
  localparam int CTL_DIV_LSB  = 2;
  localparam int CTL_MODE_LSB = 0;
  localparam int CCTL_IM      = 6;
  localparam int CCTL_CMP_LSB = 3;
  localparam int CCTL_MODE    = 2;
  localparam int OVF_MASK_BIT = 6;
  // reset values
  localparam logic [7:0] CTL_RESET      = 8'h00;
  localparam logic [7:0] CCTL_RESET     = 8'h40;
  localparam logic [7:0] CNT_RESET      = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [15:0] CC_RESET      = 16'h0000;
  // prescaler division counts
  localparam logic [6:0] DIV1_LAST   = 7'h00;
  localparam logic [6:0] DIV8_LAST   = 7'h07;
  localparam logic [6:0] DIV32_LAST  = 7'h1f;
  localparam logic [6:0] DIV128_LAST = 7'h7f;
  // counter modes
  typedef enum logic [1:0] {
    CNT_HALT,
    CNT_FREE,
    CNT_MODULO,
    CNT_UPDOWN
  } count_mode_t;
  // compare actions
  localparam logic [2:0] CMP_SET      = 3'h0;
  localparam logic [2:0] CMP_CLEAR    = 3'h1;
  localparam logic [2:0] CMP_TOGGLE   = 3'h2;
  localparam logic [2:0] CMP_SET_UP   = 3'h3;
  localparam logic [2:0] CMP_CLR_UP   = 3'h4;
  localparam logic [2:0] CMP_PWM_HIGH = 3'h6;
  localparam logic [2:0] CMP_PWM_LOW  = 3'h7;
  localparam logic [15:0] CNT_TOP     = 16'hffff;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
endpackage : tmr_pkg

// >>> rtl/chan_compare.sv
// one output compare channel: buffered compare value and pin level
// assumes the counter and tick come from the parent on the same clock
`timescale 1ns/100ps
`default_nettype none
module chan_compare #(
  parameter bit PWM_EDGE_OK = 1'b1
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        tick_in,
  input  wire logic [15:0] cnt_in,
  input  wire logic        up_in,
  input  wire logic        updown_in,
  input  wire logic        terminal_in,
  input  wire logic        cmp_en_in,
  input  wire logic [2:0]  cmp_sel_in,
  input  wire logic        low_wr_in,
  input  wire logic        high_wr_in,
  input  wire logic [7:0]  wdata_in,
  output logic             match_out,
  output logic             level_out,
  output logic [15:0]      value_out
);
  logic [7:0]  low_buf_r;
  logic [15:0] pend_r;
  logic        pend_vld_r;
  logic        zero;
  logic        immediate;
  logic        nxt;

  // modes 1..3 take a new value at once, the others wait for zero
  assign immediate = (cmp_sel_in >= tmr_pkg::CMP_CLEAR) && (cmp_sel_in <= tmr_pkg::CMP_SET_UP);
  assign zero      = tick_in && (cnt_in == tmr_pkg::CNT_ZERO);
  // one evaluation per active tick
  assign match_out = tick_in && cmp_en_in && (cnt_in == value_out); // see RULE2 see RULE20

  // low byte waits in a buffer until the high byte arrives
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_buf_r  <= 8'h00;
      pend_r     <= tmr_pkg::CC_RESET;
      pend_vld_r <= 1'b0;
      value_out  <= tmr_pkg::CC_RESET;
    end else begin
      if (low_wr_in) begin
        low_buf_r <= wdata_in; // see RULE4
      end
      if (high_wr_in && immediate) begin
        value_out  <= {wdata_in, low_buf_r}; // see RULE5
        pend_vld_r <= 1'b0;
      end else if (high_wr_in) begin
        pend_r     <= {wdata_in, low_buf_r};
        pend_vld_r <= 1'b1;
      end else if (zero && pend_vld_r) begin
        value_out  <= pend_r; // see RULE5
        pend_vld_r <= 1'b0;
      end
    end
  end

  // pin action; a match in the same tick as zero wins
  always_comb begin
    nxt = level_out;
    case (cmp_sel_in)
      tmr_pkg::CMP_SET:    if (match_out) nxt = 1'b1;
      tmr_pkg::CMP_CLEAR:  if (match_out) nxt = 1'b0;
      tmr_pkg::CMP_TOGGLE: if (match_out) nxt = ~level_out;
      tmr_pkg::CMP_SET_UP: begin
        if (match_out && up_in) nxt = 1'b1;
        else if (updown_in ? (match_out && !up_in) : zero) nxt = 1'b0;
      end
      tmr_pkg::CMP_CLR_UP: begin
        if (match_out && up_in) nxt = 1'b0;
        else if (updown_in ? (match_out && !up_in) : zero) nxt = 1'b1;
      end
      tmr_pkg::CMP_PWM_HIGH: begin
        if (!PWM_EDGE_OK) nxt = level_out; // see RULE6
        else if (match_out) nxt = 1'b1; // see RULE13
        else if (tick_in && terminal_in) nxt = 1'b0;
      end
      tmr_pkg::CMP_PWM_LOW: begin
        if (!PWM_EDGE_OK) nxt = level_out; // see RULE6
        else if (match_out) nxt = 1'b0; // see RULE13
        else if (tick_in && terminal_in) nxt = 1'b1;
      end
      default: begin
        // mode 5 inverts mode 4 in up/down; channel 0 and other counts hold
        if (PWM_EDGE_OK && updown_in && match_out) nxt = up_in; // see RULE14
      end
    endcase
  end

  // registered level keeps the pin free of glitches
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
    end else if (cmp_en_in) begin
      level_out <= nxt; // see RULE3 see RULE14
    end
  end
endmodule : chan_compare
`default_nettype wire

// >>> rtl/tick_prescale.sv
// prescaler turning the global timer tick into the counter's active tick
// assumes tick_in is a one-cycle enable from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module tick_prescale (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       tick_in,
  input  wire logic [1:0] div_sel_in,
  output logic            tick_out
);
  logic [6:0] pre_r;
  logic [6:0] last;

  // division limit picked by the divider field
  always_comb begin
    case (div_sel_in)
      2'h0:    last = tmr_pkg::DIV1_LAST;
      2'h1:    last = tmr_pkg::DIV8_LAST;
      2'h2:    last = tmr_pkg::DIV32_LAST;
      default: last = tmr_pkg::DIV128_LAST;
    endcase
  end

  // count global ticks; a shrunk divider restarts cleanly via the >= test
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_r    <= 7'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (pre_r >= last) begin
          pre_r    <= 7'h00;
          tick_out <= 1'b1;
        end else begin
          pre_r <= pre_r + 7'h01;
        end
      end
    end
  end
endmodule : tick_prescale
`default_nettype wire

// >>> rtl/timer_output_compare_irq.sv
// timer counter, compare channels, flags, interrupt request and dma triggers
// assumes a byte register port with one-cycle read/write strobes on clk_in
// Contract
// RULE1: compare-configured channel pin is driven once the timer has started.
// RULE2: counter equal to compare value sets, clears or toggles output per mode.
// RULE3: output pin edges are glitch-free within one compare mode.
// RULE4: compare low byte write is buffered until the high byte write.
// RULE5: modes 1-3 apply new value at once; others at counter zero.
// RULE6: channel 0 has no compare modes 6 and 7.
// RULE7: a compare match sets that channel's event flag.
// RULE8: one interrupt request for terminal count, capture and compare events.
// RULE9: request only when event flag and its mask bit are both set.
// RULE10: software clears a pending flag before another request for it.
// RULE11: setting a mask while its flag is set issues a new request.
// RULE12: three dma triggers, each pulsing on its channel's compare.
// RULE13: modes 6 and 7 on channels 1, 2 pick edge-aligned pwm polarity.
// RULE14: up/down mode with modes 4, 5 gives centre-aligned opposite pwm.
// RULE15: up/down period is twice channel 0 value; dead time cc1 minus cc2.
// RULE16: count high register returns byte latched at last count low read.
// RULE17: any count low write clears counter; its read returns low byte.
// RULE18: compare field: set, clear, toggle, set-up/clear-zero, and its inverse.
// RULE19: writing one to an event flag leaves it; writing zero clears it.
// RULE20: matches are evaluated once per active tick.
`timescale 1ns/100ps
`default_nettype none
module timer_output_compare_irq (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       tick_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic [2:0] capture_event_in,
  output logic [7:0]      sfr_rdata_out,
  output logic [2:0]      chan_pin_out,
  output logic [2:0]      chan_pin_oe_n_out,
  output logic            irq_req_out,
  output logic            dma_trig_chan0_out,
  output logic            dma_trig_chan1_out,
  output logic            dma_trig_chan2_out,
  output logic [15:0]     counter_value_out,
  output logic [1:0]      count_mode_out
);
  // channel index of a control register address, 3 when none
  function automatic logic [1:0] cctl_idx(input logic [7:0] a);
    case (a)
      tmr_pkg::ADDR_CCTL0: cctl_idx = 2'h0;
      tmr_pkg::ADDR_CCTL1: cctl_idx = 2'h1;
      tmr_pkg::ADDR_CCTL2: cctl_idx = 2'h2;
      default:             cctl_idx = 2'h3;
    endcase
  endfunction : cctl_idx

  // compare byte address: index in [2:1], high byte in [0], valid in [3]
  function automatic logic [3:0] cc_dec(input logic [7:0] a);
    case (a)
      tmr_pkg::ADDR_CC0L: cc_dec = 4'h8;
      tmr_pkg::ADDR_CC0H: cc_dec = 4'h9;
      tmr_pkg::ADDR_CC1L: cc_dec = 4'ha;
      tmr_pkg::ADDR_CC1H: cc_dec = 4'hb;
      tmr_pkg::ADDR_CC2L: cc_dec = 4'hc;
      tmr_pkg::ADDR_CC2H: cc_dec = 4'hd;
      default:            cc_dec = 4'h0;
    endcase
  endfunction : cc_dec

  logic [3:0]  flags_r;
  logic [1:0]  div_r;
  logic [7:0]  cctl_r [3];
  logic        ovf_mask_r;
  logic [7:0]  cnt_high_r;
  logic        up_r;
  logic        started_r;
  logic [3:0]  pend_q_r;
  logic        timer_tick;
  logic        terminal;
  logic        ovf_event;
  logic        cnt_clear;
  logic [3:0]  pend;
  logic [3:0]  flag_set;
  logic [2:0]  match;
  logic [2:0]  level;
  logic [15:0] cc_val [3];
  logic [3:0]  wr_cc;
  logic [3:0]  rd_cc;
  logic [7:0]  rd_mux;
  tmr_pkg::count_mode_t mode;

  assign mode      = tmr_pkg::count_mode_t'(count_mode_out);
  assign wr_cc     = sfr_wr_in ? cc_dec(sfr_addr_in) : 4'h0;
  assign rd_cc     = cc_dec(sfr_addr_in);
  assign cnt_clear = sfr_wr_in && (sfr_addr_in == tmr_pkg::ADDR_CNT_LOW);

  tick_prescale u_pre (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .tick_in    (tick_in),
    .div_sel_in (div_r),
    .tick_out   (timer_tick)
  );

  // end of the counting period for each counter mode
  always_comb begin
    case (mode)
      tmr_pkg::CNT_FREE:   terminal = (counter_value_out == tmr_pkg::CNT_TOP);
      tmr_pkg::CNT_MODULO: terminal = (counter_value_out == cc_val[0]);
      tmr_pkg::CNT_UPDOWN: terminal = up_r && (counter_value_out == cc_val[0]);
      default:             terminal = 1'b0;
    endcase
  end

  // up/down does not raise the terminal count flag
  assign ovf_event = timer_tick && terminal && (mode != tmr_pkg::CNT_UPDOWN);

  // the 16-bit counter; a clear from software outranks a tick
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      counter_value_out <= tmr_pkg::CNT_ZERO;
      up_r              <= 1'b1;
    end else if (cnt_clear) begin
      counter_value_out <= tmr_pkg::CNT_ZERO; // see RULE17
      up_r              <= 1'b1;
    end else if (timer_tick) begin
      case (mode)
        tmr_pkg::CNT_FREE, tmr_pkg::CNT_MODULO: begin
          if (terminal) counter_value_out <= tmr_pkg::CNT_ZERO;
          else counter_value_out <= counter_value_out + 16'h0001;
        end
        tmr_pkg::CNT_UPDOWN: begin
          // turn at channel 0 value and at zero: period is twice that value
          if (up_r && (counter_value_out >= cc_val[0])) begin
            up_r <= 1'b0; // see RULE15
            if (counter_value_out != tmr_pkg::CNT_ZERO) begin
              counter_value_out <= counter_value_out - 16'h0001;
            end
          end else if (!up_r && (counter_value_out == tmr_pkg::CNT_ZERO)) begin
            up_r <= 1'b1;
            if (cc_val[0] != tmr_pkg::CNT_ZERO) begin
              counter_value_out <= counter_value_out + 16'h0001;
            end
          end else if (up_r) begin
            counter_value_out <= counter_value_out + 16'h0001;
          end else begin
            counter_value_out <= counter_value_out - 16'h0001;
          end
        end
        default: counter_value_out <= counter_value_out;
      endcase
    end
  end

  // control and status register: divider, mode and event flags
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r          <= tmr_pkg::CTL_RESET[tmr_pkg::CTL_DIV_LSB +: 2];
      count_mode_out <= tmr_pkg::CTL_RESET[tmr_pkg::CTL_MODE_LSB +: 2];
    end else if (sfr_wr_in && (sfr_addr_in == tmr_pkg::ADDR_CTL)) begin
      div_r          <= sfr_wdata_in[tmr_pkg::CTL_DIV_LSB +: 2];
      count_mode_out <= sfr_wdata_in[tmr_pkg::CTL_MODE_LSB +: 2];
    end
  end

  // flag order is {ch2, ch1, ch0, terminal}; captures share the channel flags
  assign flag_set = {match | capture_event_in, ovf_event}; // see RULE7 see RULE8

  // writing zero clears, writing one keeps; a same-cycle event still wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_r <= tmr_pkg::CTL_RESET[tmr_pkg::CTL_FLAG_LSB +: 4];
    end else if (sfr_wr_in && (sfr_addr_in == tmr_pkg::ADDR_CTL)) begin
      flags_r <= (flags_r & sfr_wdata_in[tmr_pkg::CTL_FLAG_LSB +: 4]) | flag_set; // see RULE19
    end else begin
      flags_r <= flags_r | flag_set;
    end
  end

  // channel control registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 3; i++) begin
        cctl_r[i] <= tmr_pkg::CCTL_RESET;
      end
    end else if (sfr_wr_in && (cctl_idx(sfr_addr_in) != 2'h3)) begin
      cctl_r[cctl_idx(sfr_addr_in)] <= sfr_wdata_in;
    end
  end

  // terminal count mask lives in its own register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ovf_mask_r <= tmr_pkg::IRQ_MASK_RESET[tmr_pkg::OVF_MASK_BIT];
    end else if (sfr_wr_in && (sfr_addr_in == tmr_pkg::ADDR_IRQ_MASK)) begin
      ovf_mask_r <= sfr_wdata_in[tmr_pkg::OVF_MASK_BIT];
    end
  end

  // three compare channels; channel 0 lacks the edge pwm modes
  for (genvar g = 0; g < 3; g++) begin : g_chan
    chan_compare #(
      .PWM_EDGE_OK (g != 0)
    ) u_chan (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .tick_in     (timer_tick),
      .cnt_in      (counter_value_out),
      .up_in       (up_r),
      .updown_in   (mode == tmr_pkg::CNT_UPDOWN),
      .terminal_in (terminal),
      .cmp_en_in   (cctl_r[g][tmr_pkg::CCTL_MODE] && started_r),
      .cmp_sel_in  (cctl_r[g][tmr_pkg::CCTL_CMP_LSB +: 3]), // see RULE18
      .low_wr_in   (wr_cc[3] && (wr_cc[2:1] == 2'(g)) && !wr_cc[0]),
      .high_wr_in  (wr_cc[3] && (wr_cc[2:1] == 2'(g)) && wr_cc[0]),
      .wdata_in    (sfr_wdata_in),
      .match_out   (match[g]),
      .level_out   (level[g]),
      .value_out   (cc_val[g])
    );
  end

  // the timer counts as started once any counting mode is chosen
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      started_r <= 1'b0;
    end else if (mode != tmr_pkg::CNT_HALT) begin
      started_r <= 1'b1;
    end
  end

  // pins: enable is low while driving; a capture channel releases its pin
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan_pin_out      <= 3'h0;
      chan_pin_oe_n_out <= 3'h7;
    end else begin
      chan_pin_out <= level; // see RULE3
      for (int i = 0; i < 3; i++) begin
        chan_pin_oe_n_out[i] <= !(cctl_r[i][tmr_pkg::CCTL_MODE] && started_r); // see RULE1
      end
    end
  end

  // dma triggers follow each channel's match one cycle later
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dma_trig_chan0_out <= 1'b0;
      dma_trig_chan1_out <= 1'b0;
      dma_trig_chan2_out <= 1'b0;
    end else begin
      dma_trig_chan0_out <= match[0]; // see RULE12
      dma_trig_chan1_out <= match[1]; // see RULE12
      dma_trig_chan2_out <= match[2]; // see RULE12
    end
  end

  // masked pending events; a request fires only on a new pending bit
  assign pend = flags_r & {cctl_r[2][tmr_pkg::CCTL_IM], cctl_r[1][tmr_pkg::CCTL_IM],
                           cctl_r[0][tmr_pkg::CCTL_IM], ovf_mask_r}; // see RULE9

  // a still-set flag blocks a repeat, but unmasking a set flag re-fires
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q_r    <= 4'h0;
      irq_req_out <= 1'b0;
    end else begin
      pend_q_r    <= pend;
      irq_req_out <= |(pend & ~pend_q_r); // see RULE8 see RULE10 see RULE11
    end
  end

  // read data mux
  always_comb begin
    rd_mux = 8'h00;
    if (rd_cc[3]) begin
      rd_mux = rd_cc[0] ? cc_val[rd_cc[2:1]][15:8] : cc_val[rd_cc[2:1]][7:0];
    end else if (cctl_idx(sfr_addr_in) != 2'h3) begin
      rd_mux = cctl_r[cctl_idx(sfr_addr_in)];
    end else begin
      case (sfr_addr_in)
        tmr_pkg::ADDR_CNT_LOW:  rd_mux = counter_value_out[7:0]; // see RULE17
        tmr_pkg::ADDR_CNT_HIGH: rd_mux = cnt_high_r; // see RULE16
        tmr_pkg::ADDR_CTL:      rd_mux = {flags_r, div_r, count_mode_out};
        tmr_pkg::ADDR_IRQ_MASK: rd_mux = 8'(ovf_mask_r) << tmr_pkg::OVF_MASK_BIT;
        default:                rd_mux = 8'h00;
      endcase
    end
  end

  // read data register and the high byte snapshot on a low byte read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sfr_rdata_out <= 8'h00;
      cnt_high_r    <= tmr_pkg::CNT_RESET;
    end else if (sfr_rd_in) begin
      sfr_rdata_out <= rd_mux;
      if (sfr_addr_in == tmr_pkg::ADDR_CNT_LOW) begin
        cnt_high_r <= counter_value_out[15:8]; // see RULE16
      end
    end
  end
endmodule : timer_output_compare_irq
`default_nettype wire

// >>> tb/load_model.sv
// model of the loads hung on the three timer pins, e.g. an h-bridge
// assumes pins are sampled on clk_in; a released pin is pulled down
`timescale 1ns/100ps
`default_nettype none
module load_model (
  input  wire logic       clk_in,
  input  wire logic [2:0] pin_in,
  input  wire logic [2:0] oe_n_in,
  output logic [2:0]      load_on_out,
  output int              overlap_out
);
  int overlap_r = 0;
  // an undriven pin reads as the pull-down level, so no load turns on
  assign load_on_out = pin_in & ~oe_n_in;
  assign overlap_out = overlap_r;
  // both bridge halves on at once means cross-conduction
  always_ff @(posedge clk_in) begin
    if (load_on_out[1] && load_on_out[2]) begin
      overlap_r <= overlap_r + 1;
    end
  end
endmodule : load_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the timer compare, flag and count registers
// assumes the byte register port and one 250 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        tick_in = 1'b0;
  logic [7:0]  sfr_addr_in = 8'h00;
  logic        sfr_wr_in = 1'b0;
  logic        sfr_rd_in = 1'b0;
  logic [7:0]  sfr_wdata_in = 8'h00;
  logic [2:0]  cap = 3'h0;
  logic [7:0]  sfr_rdata_out;
  logic [2:0]  pin;
  logic [2:0]  oe_n;
  logic        irq;
  logic [2:0]  dma;
  logic [15:0] counter_value_out;
  logic [1:0]  count_mode_out;
  logic [2:0]  load_on;
  int          overlap;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_irq = 0;
  int          n_dma1 = 0;
  timer_output_compare_irq dut_u (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .capture_event_in(cap), .sfr_rdata_out(sfr_rdata_out),
    .chan_pin_out(pin), .chan_pin_oe_n_out(oe_n), .irq_req_out(irq),
    .dma_trig_chan0_out(dma[0]), .dma_trig_chan1_out(dma[1]), .dma_trig_chan2_out(dma[2]),
    .counter_value_out(counter_value_out), .count_mode_out(count_mode_out));
  load_model load_u (.clk_in(clk_in), .pin_in(pin), .oe_n_in(oe_n),
    .load_on_out(load_on), .overlap_out(overlap));
  // 4 ns clock; tick every second clock so matches never repeat back to back
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) tick_in <= ~tick_in;
  // pulse counters for request and channel 1 trigger
  always @(posedge clk_in) begin
    if (irq === 1'b1) n_irq++;
    if (dma[1] === 1'b1) n_dma1++;
  end
  task automatic chk(input bit good, input string m);
    cmp_count++;
    if (!good) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in  <= a;
    sfr_wdata_in <= d;
    sfr_wr_in    <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_in <= a;
    sfr_rd_in   <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    @(posedge clk_in);
    d = sfr_rdata_out;
  endtask : rd
  // free-running count from zero for n clocks, then halt keeping flags
  task automatic run(input int n);
    wr(tmr_pkg::ADDR_CNT_LOW, 8'h00);
    wr(tmr_pkg::ADDR_CTL, 8'h01);
    repeat (n) @(posedge clk_in);
    wr(tmr_pkg::ADDR_CTL, 8'hf0);
  endtask : run
  task automatic t_modes;
    logic [2:0] m;
    logic [7:0] d;
    wr(tmr_pkg::ADDR_CCTL2, 8'h14);
    wr(tmr_pkg::ADDR_CC2L, 8'h10);
    wr(tmr_pkg::ADDR_CC2H, 8'h00);
    for (int i = 0; i < 3; i++) begin
      m = 3'(i);
      wr(tmr_pkg::ADDR_CCTL2, {2'h0, m, 3'h4});
      run(50);
      chk(pin[2] === (i != 1), "channel 2 action");
    end
    rd(tmr_pkg::ADDR_CCTL0, d);
    chk(d === tmr_pkg::CCTL_RESET, "control reset value");
    $display("test modes done");
  endtask : t_modes
  task automatic t_chan1;
    logic [7:0] d;
    wr(tmr_pkg::ADDR_CCTL1, 8'h14); // toggle, mask off
    wr(tmr_pkg::ADDR_CC1L, 8'h20);
    rd(tmr_pkg::ADDR_CC1L, d);
    chk(d === 8'h00, "low byte not buffered");
    wr(tmr_pkg::ADDR_CC1H, 8'h00);
    rd(tmr_pkg::ADDR_CC1L, d);
    chk(d === 8'h20, "value not applied");
    n_irq  = 0;
    n_dma1 = 0;
    run(90);
    chk(pin[1] === 1'b1 && oe_n[1] === 1'b0, "channel 1 toggle");
    chk(load_on[1] === 1'b1, "load not on");
    chk(n_dma1 == 1, "trigger count");
    chk(n_irq == 0, "masked request");
    rd(tmr_pkg::ADDR_CTL, d);
    chk(d[6] === 1'b1, "flag not set or lost");
    wr(tmr_pkg::ADDR_CCTL1, 8'h54);
    repeat (4) @(posedge clk_in);
    chk(n_irq == 1, "mask enable request");
    wr(tmr_pkg::ADDR_CTL, 8'hb0);
    rd(tmr_pkg::ADDR_CTL, d);
    chk(d[6] === 1'b0, "flag not cleared");
    $display("test chan1 done");
  endtask : t_chan1
  task automatic t_count;
    logic [7:0] d;
    logic [7:0] h;
    run(600);
    rd(tmr_pkg::ADDR_CNT_LOW, d);
    rd(tmr_pkg::ADDR_CNT_HIGH, h);
    chk(h > 8'h00, "high byte empty");
    wr(tmr_pkg::ADDR_CNT_LOW, 8'h5a);
    wr(tmr_pkg::ADDR_CNT_HIGH, 8'hff);
    rd(tmr_pkg::ADDR_CNT_HIGH, d);
    chk(d === h, "latch moved without low read");
    rd(tmr_pkg::ADDR_CNT_LOW, d);
    chk(d === 8'h00, "count not cleared");
    rd(tmr_pkg::ADDR_CNT_HIGH, d);
    chk(d === 8'h00, "high after clear");
    rd(8'h00, d);
    chk(d === 8'h00, "unmapped read");
    $display("test count done");
  endtask : t_count
  task automatic t_reset;
    logic [7:0] d;
    int         o;
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    o = overlap;
    chk(pin === 3'h0 && oe_n === 3'h7, "pins after reset");
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(tmr_pkg::ADDR_CCTL1, d);
    chk(d === tmr_pkg::CCTL_RESET, "control after reset");
    // channel 0 mask is set out of reset, so a capture must request
    n_irq = 0;
    cap <= 3'h1;
    @(posedge clk_in);
    cap <= 3'h0;
    repeat (4) @(posedge clk_in);
    chk(n_irq == 1 && overlap == o, "capture request or released load");
    $display("test reset done");
  endtask : t_reset
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_modes();
    t_chan1();
    t_count();
    t_reset();
    tally_and_finish();
  end
  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    #80000;
    n_errors++;
    $display("BAD %0t watchdog", $time);
    tally_and_finish();
  end
endmodule : tb
bind timer_output_compare_irq tmr_props props_u (.clk_in(clk_in), .rst_in(rst_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
  .sfr_rdata_out(sfr_rdata_out), .chan_pin_out(chan_pin_out),
  .chan_pin_oe_n_out(chan_pin_oe_n_out), .irq_req_out(irq_req_out),
  .dma_trig_chan0_out(dma_trig_chan0_out), .dma_trig_chan1_out(dma_trig_chan1_out),
  .dma_trig_chan2_out(dma_trig_chan2_out), .counter_value_out(counter_value_out),
  .count_mode_out(count_mode_out));
`default_nettype wire

// >>> tb/timer_output_compare_irq_properties.sv
// concurrent checks on the ports of the timer compare block
// assumes tick_in pulses no more often than every second clock
`timescale 1ns/100ps
`default_nettype none
module tmr_props (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  sfr_addr_in,
  input wire logic        sfr_wr_in,
  input wire logic        sfr_rd_in,
  input wire logic [7:0]  sfr_rdata_out,
  input wire logic [2:0]  chan_pin_out,
  input wire logic [2:0]  chan_pin_oe_n_out,
  input wire logic        irq_req_out,
  input wire logic        dma_trig_chan0_out,
  input wire logic        dma_trig_chan1_out,
  input wire logic        dma_trig_chan2_out,
  input wire logic [15:0] counter_value_out,
  input wire logic [1:0]  count_mode_out
);
  logic       rd_lo;
  logic       rd_hi;
  logic       dma_any;
  logic [7:0] cnt_hi;
  logic [7:0] cnt_lo;
  // decoded strobes keep the properties short
  assign rd_lo   = sfr_rd_in && sfr_addr_in == tmr_pkg::ADDR_CNT_LOW;
  assign rd_hi   = sfr_rd_in && sfr_addr_in == tmr_pkg::ADDR_CNT_HIGH;
  assign dma_any = dma_trig_chan0_out || dma_trig_chan1_out || dma_trig_chan2_out;
  assign cnt_hi  = counter_value_out[15:8];
  assign cnt_lo  = counter_value_out[7:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reset_state_a: assert property ($past(rst_in) |-> chan_pin_oe_n_out == 3'h7
    && !irq_req_out && counter_value_out == 16'h0000 && count_mode_out == 2'h0)
    else $error("outputs not at reset level");
  cnt_clear_a: assert property (
    sfr_wr_in && sfr_addr_in == tmr_pkg::ADDR_CNT_LOW |=> counter_value_out == 16'h0000)
    else $error("count low write did not clear counter");
  cnt_low_a: assert property (rd_lo |=> sfr_rdata_out == $past(cnt_lo))
    else $error("count low read wrong");
  cnt_latch_a: assert property (rd_lo ##1 !rd_lo ##1 rd_hi |=>
    sfr_rdata_out == $past(cnt_hi, 3)) else $error("count high not latched");
  cnt_step_a: assert property ($changed(counter_value_out) |->
    counter_value_out == $past(counter_value_out) + 16'h0001
    || counter_value_out == $past(counter_value_out) - 16'h0001
    || counter_value_out == 16'h0000) else $error("counter jumped");
  pin_glitch_a: assert property ($changed(chan_pin_out) |=> $stable(chan_pin_out))
    else $error("pin glitch");
  dma_pulse_a: assert property (dma_any |=> !dma_any)
    else $error("dma trigger longer than one cycle");
  irq_pulse_a: assert property (irq_req_out |=> !irq_req_out)
    else $error("interrupt request held");
endmodule : tmr_props
`default_nettype wire
